/* include/sstx_pkg.sv */
// package for the serial transmit clock and frame block
package sstx_pkg;
  localparam logic [31:0] SSTX_ADDR_CTRL      = 32'hF0010000;
  localparam logic [31:0] SSTX_ADDR_CLK_MODE  = 32'hF0010018;
  localparam logic [31:0] SSTX_ADDR_FRM_MODE  = 32'hF001001C;
  localparam logic [31:0] SSTX_ADDR_RX_HOLD   = 32'hF0010020;
  localparam logic [31:0] SSTX_ADDR_TX_HOLD   = 32'hF0010024;
  localparam logic [31:0] SSTX_ADDR_SYNC_HOLD = 32'hF0010034;
  localparam logic [31:0] SSTX_ADDR_STATUS    = 32'hF0010040;
  localparam logic [31:0] SSTX_ADDR_WPROT     = 32'hF00100E4;
  localparam int SSTX_CTRL_TX_EN_BIT   = 0;
  localparam int SSTX_CTRL_MDRIVE_BIT  = 1;
  localparam int SSTX_STAT_TX_SYNC_BIT = 10;
  localparam int SSTX_STAT_TX_EN_BIT   = 16;
  localparam int SSTX_WPROT_EN_BIT     = 0;
  localparam int SSTX_EXT_WEIGHT       = 16;
  localparam int SSTX_SYNC_WIDTH       = 16;
  localparam int SSTX_MCK_HALF_CYCLES  = 2;
  localparam logic [31:0] SSTX_RESET_WORD = 32'h00000000;

  typedef struct packed {
    logic [7:0] period;
    logic [7:0] start_delay;
    logic [3:0] reserved;
    logic [3:0] start_select;
    logic [1:0] tx_clock_gating;
    logic       tx_clock_invert;
    logic [2:0] tx_clock_output_select;
    logic [1:0] tx_clock_source_select;
  } sstx_clk_mode_t;

  typedef struct packed {
    logic [3:0] sync_length_extension;
    logic [2:0] reserved_hi;
    logic       sync_edge_select;
    logic       sync_data_enable;
    logic [2:0] sync_output_select;
    logic [3:0] sync_length;
    logic [3:0] reserved_mid;
    logic [3:0] words_per_frame;
    logic       bit_order;
    logic       reserved_lo;
    logic       idle_data_level;
    logic [4:0] word_length;
  } sstx_frm_mode_t;

  typedef enum logic [1:0] {
    SSTX_IDLE  = 2'b00,
    SSTX_DELAY = 2'b01,
    SSTX_DATA  = 2'b11
  } sstx_state_t;
endpackage

/* hdl/sstx_core.sv */
// transmit clock, frame sync and data sequencer with its registers
//
// Operation
// - source select picks divided, tx pin, rx pin
// - clock output none, continuous, or transfer only
// - invert bit swaps shift and sample edges
// - inversion never reaches the clock pin
// - gating by frame pin low or high
// - start on holding write, or with receiver
// - start on frame pin level, edge, compare
// - start delay counts clocks before data
// - delay also applies to receiver start
// - period field makes sync every 2(p+1)
// - frame mode writes ignored while protected
// - word length field plus one bits
// - idle level on pin, multi-drive enable
// - bit order selects lsb or msb first
// - words per frame field plus one words
// - sync length plus sixteen extension plus one
// - frame sync output shapes by select field
// - sync data shifted out during sync
// - edge select chooses which sync edge flags
// - received word stored right aligned
// - sync flag sticky, cleared by status read
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module sstx_core
  import sstx_pkg::*;
#(
  parameter int DATA_WIDTH = 32,
  parameter int MCK_HALF   = SSTX_MCK_HALF_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_write,
  input  wire logic        bus_read,
  output logic      [31:0] bus_rdata,
  input  wire logic        tx_clock_pin_level,
  output logic             tx_clock_pin_value,
  output logic             tx_clock_pin_oe,
  input  wire logic        rx_clock_pin_level,
  input  wire logic        tx_frame_pin_level,
  output logic             tx_frame_pin_value,
  output logic             tx_frame_pin_oe,
  output logic             serial_out_pin_value,
  output logic             serial_out_pin_oe,
  input  wire logic        rx_start,
  input  wire logic        compare0_event,
  input  wire logic [31:0] received_word,
  input  wire logic        received_word_valid
);
  sstx_clk_mode_t  clk_mode_reg;
  sstx_frm_mode_t  frm_mode_reg;
  logic [31:0]     rx_holding_reg;
  logic [DATA_WIDTH-1:0] tx_holding_reg;
  logic            hold_full_reg;
  logic [SSTX_SYNC_WIDTH-1:0] sync_holding_reg;
  logic            tx_en_reg;
  logic            mdrive_reg;
  logic            wprot_reg;
  logic            tx_sync_reg;
  sstx_state_t     state_reg;
  logic [DATA_WIDTH-1:0] shift_reg;
  logic [4:0]      bit_cnt_reg;
  logic [3:0]      word_cnt_reg;
  logic [7:0]      delay_cnt_reg;
  logic [8:0]      sync_cnt_reg;
  logic            sync_act_reg;
  logic [8:0]      per_cnt_reg;
  logic            start_pend_reg;
  logic            toggle_reg;
  logic            fs_prev_reg;
  logic            tf_prev_reg;
  logic            clk_prev_reg;
  logic            mck_reg;
  logic [7:0]      mck_cnt_reg;
  logic            sel_clk;
  logic            shift_tick;
  logic            sample_tick;
  logic            gate_ok;
  logic            start_evt;
  logic            per_pulse;
  logic            load_word;
  logic            last_bit;
  logic [8:0]      sync_len;
  logic [4:0]      data_idx;
  logic [8:0]      sync_idx;
  logic            data_bit;
  logic            sync_bit;
  logic            out_level;
  logic            fs_level;
  logic            fs_seen;
  logic            status_read;

  assign status_read = bus_read && (bus_addr == SSTX_ADDR_STATUS);

  // divided system clock, free running
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mck_cnt_reg <= 8'h00;
      mck_reg     <= 1'b0;
    end else if (mck_cnt_reg == 8'(MCK_HALF - 1)) begin
      mck_cnt_reg <= 8'h00;
      mck_reg     <= ~mck_reg;
    end else begin
      mck_cnt_reg <= mck_cnt_reg + 8'h01;
    end
  end

  always_comb begin
    case (clk_mode_reg.tx_clock_source_select)
      2'h0:    sel_clk = mck_reg;
      2'h1:    sel_clk = tx_clock_pin_level;
      2'h2:    sel_clk = rx_clock_pin_level;
      default: sel_clk = 1'b0;
    endcase
    case (clk_mode_reg.tx_clock_gating)
      2'h1:    gate_ok = !tx_frame_pin_level;
      2'h2:    gate_ok = tx_frame_pin_level;
      default: gate_ok = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= sel_clk;
    end
  end

  // shift on falling edge unless inverted; sampling takes the other edge
  assign shift_tick  = gate_ok && (clk_mode_reg.tx_clock_invert ?
                       (sel_clk && !clk_prev_reg) : (!sel_clk && clk_prev_reg));
  assign sample_tick = gate_ok && (clk_mode_reg.tx_clock_invert ?
                       (!sel_clk && clk_prev_reg) : (sel_clk && !clk_prev_reg));

  // clock pin carries the uninverted clock; output select 1, or 2 while not idle, drives it out for every source except the tx pin
  assign tx_clock_pin_value = sel_clk;
  assign tx_clock_pin_oe    = (clk_mode_reg.tx_clock_source_select != 2'h1) &&
                              ((clk_mode_reg.tx_clock_output_select == 3'h1) ||
                               ((clk_mode_reg.tx_clock_output_select == 3'h2) &&
                                (state_reg != SSTX_IDLE)));

  // register writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_mode_reg     <= SSTX_RESET_WORD;
      frm_mode_reg     <= SSTX_RESET_WORD;
      sync_holding_reg <= '0;
      tx_en_reg        <= 1'b0;
      mdrive_reg       <= 1'b0;
      wprot_reg        <= 1'b0;
    end else if (bus_write) begin
      if (bus_addr == SSTX_ADDR_CTRL) begin
        tx_en_reg  <= bus_wdata[SSTX_CTRL_TX_EN_BIT];
        mdrive_reg <= bus_wdata[SSTX_CTRL_MDRIVE_BIT];
      end else if (bus_addr == SSTX_ADDR_CLK_MODE && !wprot_reg) begin
        clk_mode_reg <= bus_wdata;
      end else if (bus_addr == SSTX_ADDR_FRM_MODE && !wprot_reg) begin
        frm_mode_reg <= bus_wdata;
      end else if (bus_addr == SSTX_ADDR_SYNC_HOLD) begin
        sync_holding_reg <= bus_wdata[SSTX_SYNC_WIDTH-1:0];
      end else if (bus_addr == SSTX_ADDR_WPROT) begin
        wprot_reg <= bus_wdata[SSTX_WPROT_EN_BIT];
      end
    end
  end

  // holding registers; a new write wins over the load that empties it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_holding_reg <= '0;
      hold_full_reg  <= 1'b0;
      rx_holding_reg <= 32'h00000000;
    end else begin
      if (bus_write && bus_addr == SSTX_ADDR_TX_HOLD) begin
        tx_holding_reg <= bus_wdata[DATA_WIDTH-1:0];
        hold_full_reg  <= 1'b1;
      end else if (load_word) begin
        hold_full_reg <= 1'b0;
      end
      if (received_word_valid) begin
        rx_holding_reg <= received_word;
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 32'h00000000;
    end else if (!bus_read) begin
      bus_rdata <= 32'h00000000;
    end else if (bus_addr == SSTX_ADDR_CTRL) begin
      bus_rdata <= {30'h00000000, mdrive_reg, tx_en_reg};
    end else if (bus_addr == SSTX_ADDR_CLK_MODE) begin
      bus_rdata <= clk_mode_reg;
    end else if (bus_addr == SSTX_ADDR_FRM_MODE) begin
      bus_rdata <= frm_mode_reg;
    end else if (bus_addr == SSTX_ADDR_RX_HOLD) begin
      bus_rdata <= rx_holding_reg;
    end else if (bus_addr == SSTX_ADDR_SYNC_HOLD) begin
      bus_rdata <= 32'(sync_holding_reg);
    end else if (bus_addr == SSTX_ADDR_STATUS) begin
      bus_rdata <= (32'(tx_sync_reg) << SSTX_STAT_TX_SYNC_BIT) |
                   (32'(tx_en_reg) << SSTX_STAT_TX_EN_BIT);
    end else if (bus_addr == SSTX_ADDR_WPROT) begin
      bus_rdata <= 32'(wprot_reg);
    end else begin
      bus_rdata <= 32'h00000000;
    end
  end

  // start events are latched until the next shift tick in idle
  always_comb begin
    case (clk_mode_reg.start_select)
      4'h1:    start_evt = rx_start;
      4'h2:    start_evt = sample_tick && !tx_frame_pin_level;
      4'h3:    start_evt = sample_tick && tx_frame_pin_level;
      4'h4:    start_evt = sample_tick && tf_prev_reg && !tx_frame_pin_level;
      4'h5:    start_evt = sample_tick && !tf_prev_reg && tx_frame_pin_level;
      4'h6,
      4'h7:    start_evt = sample_tick && (tf_prev_reg != tx_frame_pin_level);
      4'h8:    start_evt = compare0_event;
      default: start_evt = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tf_prev_reg    <= 1'b0;
      start_pend_reg <= 1'b0;
    end else begin
      if (sample_tick) begin
        tf_prev_reg <= tx_frame_pin_level;
      end
      if (!tx_en_reg) begin
        start_pend_reg <= 1'b0;
      end else if (start_evt) begin
        start_pend_reg <= 1'b1;
      end else if (shift_tick && state_reg == SSTX_IDLE) begin
        start_pend_reg <= 1'b0;
      end
    end
  end

  assign last_bit  = (bit_cnt_reg == frm_mode_reg.word_length);
  assign load_word = shift_tick && (
    (state_reg == SSTX_IDLE && tx_en_reg && frm_mode_reg.word_length != 5'h00 &&
     clk_mode_reg.start_delay == 8'h00 &&
     (clk_mode_reg.start_select == 4'h0 ? hold_full_reg : start_pend_reg)) ||
    (state_reg == SSTX_DELAY && delay_cnt_reg == 8'h01) ||
    (state_reg == SSTX_DATA && last_bit && word_cnt_reg != frm_mode_reg.words_per_frame));

  // frame sequencer, advanced only on shift ticks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= SSTX_IDLE;
      delay_cnt_reg <= 8'h00;
      bit_cnt_reg   <= 5'h00;
      word_cnt_reg  <= 4'h0;
      shift_reg     <= '0;
    end else if (shift_tick) begin
      case (state_reg)
        SSTX_IDLE: begin
          // illegal one-bit words keep the transmitter parked
          if (tx_en_reg && frm_mode_reg.word_length != 5'h00 &&
              (clk_mode_reg.start_select == 4'h0 ? hold_full_reg : start_pend_reg)) begin
            delay_cnt_reg <= clk_mode_reg.start_delay;
            word_cnt_reg  <= 4'h0;
            bit_cnt_reg   <= 5'h00;
            if (clk_mode_reg.start_delay == 8'h00) begin
              state_reg <= SSTX_DATA;
              shift_reg <= tx_holding_reg;
            end else begin
              state_reg <= SSTX_DELAY;
            end
          end
        end
        SSTX_DELAY: begin
          delay_cnt_reg <= delay_cnt_reg - 8'h01;
          if (delay_cnt_reg == 8'h01) begin
            state_reg <= SSTX_DATA;
            shift_reg <= tx_holding_reg;
          end
        end
        SSTX_DATA: begin
          if (!last_bit) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
          end else if (word_cnt_reg == frm_mode_reg.words_per_frame) begin
            state_reg <= SSTX_IDLE;
          end else begin
            word_cnt_reg <= word_cnt_reg + 4'h1;
            bit_cnt_reg  <= 5'h00;
            shift_reg    <= tx_holding_reg;
          end
        end
        default: state_reg <= SSTX_IDLE;
      endcase
    end
  end

  assign sync_len  = 9'(frm_mode_reg.sync_length) +
                     9'(frm_mode_reg.sync_length_extension) * 9'(SSTX_EXT_WEIGHT) + 9'h001;
  // period counter spans 2*(p+1) shift ticks
  assign per_pulse = shift_tick && clk_mode_reg.period != 8'h00 &&
                     per_cnt_reg == {clk_mode_reg.period, 1'b1};

  // sync pulse runs beside the delay; a short delay lets data cut it off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt_reg  <= 9'h000;
      sync_cnt_reg <= 9'h000;
      sync_act_reg <= 1'b0;
      toggle_reg   <= 1'b0;
    end else if (shift_tick) begin
      per_cnt_reg <= (per_pulse || clk_mode_reg.period == 8'h00) ? 9'h000 :
                     per_cnt_reg + 9'h001;
      if ((state_reg == SSTX_IDLE && load_word) ||
          (state_reg == SSTX_IDLE && tx_en_reg && (clk_mode_reg.start_select == 4'h0 ?
           hold_full_reg : start_pend_reg) && frm_mode_reg.word_length != 5'h00) ||
          per_pulse) begin
        sync_act_reg <= 1'b1;
        sync_cnt_reg <= 9'h000;
        toggle_reg   <= ~toggle_reg;
      end else if (sync_act_reg) begin
        if (sync_cnt_reg == sync_len - 9'h001) begin
          sync_act_reg <= 1'b0;
        end
        sync_cnt_reg <= sync_cnt_reg + 9'h001;
      end
    end
  end

  assign data_idx = frm_mode_reg.bit_order ?
                    frm_mode_reg.word_length - bit_cnt_reg : bit_cnt_reg;
  assign data_bit = shift_reg[data_idx];
  assign sync_idx = frm_mode_reg.bit_order ? sync_len - 9'h001 - sync_cnt_reg : sync_cnt_reg;
  // sync data longer than the holding word pads with the idle level
  assign sync_bit = (sync_idx < 9'(SSTX_SYNC_WIDTH)) ?
                    sync_holding_reg[sync_idx[3:0]] : frm_mode_reg.idle_data_level;

  always_comb begin
    if (state_reg == SSTX_DATA) begin
      out_level = data_bit;
    end else if (sync_act_reg && frm_mode_reg.sync_data_enable) begin
      out_level = sync_bit;
    end else begin
      out_level = frm_mode_reg.idle_data_level;
    end
    case (frm_mode_reg.sync_output_select)
      3'h1:    fs_level = !sync_act_reg;
      3'h2:    fs_level = sync_act_reg;
      3'h3:    fs_level = state_reg != SSTX_DATA;
      3'h4:    fs_level = state_reg == SSTX_DATA;
      3'h5:    fs_level = toggle_reg;
      default: fs_level = 1'b0;
    endcase
  end

  assign fs_seen = tx_frame_pin_oe ? tx_frame_pin_value : tx_frame_pin_level;

  // serial and frame pins from flip-flops; sync flag set wins over the clearing read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out_pin_value <= 1'b0;
      serial_out_pin_oe    <= 1'b0;
      tx_frame_pin_value   <= 1'b0;
      tx_frame_pin_oe      <= 1'b0;
      fs_prev_reg          <= 1'b0;
      tx_sync_reg          <= 1'b0;
    end else begin
      serial_out_pin_value <= out_level;
      serial_out_pin_oe    <= !mdrive_reg || out_level;
      tx_frame_pin_value   <= fs_level;
      tx_frame_pin_oe      <= frm_mode_reg.sync_output_select inside {3'h1, 3'h2, 3'h3,
                                                                   3'h4, 3'h5};
      fs_prev_reg          <= fs_seen;
      if (frm_mode_reg.sync_edge_select ? (fs_prev_reg && !fs_seen) :
                                          (!fs_prev_reg && fs_seen)) begin
        tx_sync_reg <= 1'b1;
      end else if (status_read) begin
        tx_sync_reg <= 1'b0;
      end
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_wprot_hold: assert property (bus_write && bus_addr == SSTX_ADDR_FRM_MODE && wprot_reg
    |=> $stable(frm_mode_reg)) else $error("frame mode changed while protected");
  chk_delay_end: assert property (shift_tick && state_reg == SSTX_DELAY &&
    delay_cnt_reg == 8'h01 |=> state_reg == SSTX_DATA) else $error("delay did not end");
  chk_delay_run: assert property (shift_tick && state_reg == SSTX_DELAY &&
    delay_cnt_reg > 8'h01 |=> state_reg == SSTX_DELAY) else $error("delay ended early");
  chk_data_bit: assert property (state_reg == SSTX_DATA
    |=> serial_out_pin_value == $past(data_bit)) else $error("wrong data bit on pin");
  chk_idle_level: assert property (state_reg == SSTX_IDLE && !sync_act_reg
    |=> serial_out_pin_value == $past(frm_mode_reg.idle_data_level))
    else $error("idle level wrong");
  chk_sync_length: assert property ($fell(sync_act_reg)
    |-> $past(sync_cnt_reg) == $past(sync_len) - 9'h001) else $error("sync length wrong");
  chk_frame_words: assert property ($past(state_reg) == SSTX_DATA && state_reg == SSTX_IDLE
    |-> $past(word_cnt_reg) == $past(frm_mode_reg.words_per_frame))
    else $error("frame ended early");
  chk_sync_sticky: assert property (tx_sync_reg && !status_read
    |=> tx_sync_reg) else $error("sync flag lost");
  chk_clk_pin_off: assert property (clk_mode_reg.tx_clock_output_select == 3'h0
    |-> !tx_clock_pin_oe) else $error("clock pin driven in input mode");
  chk_cont_start: assert property (shift_tick && state_reg == SSTX_IDLE && tx_en_reg &&
    clk_mode_reg.start_select == 4'h0 && hold_full_reg && frm_mode_reg.word_length != 5'h00
    |=> state_reg != SSTX_IDLE) else $error("continuous start missed");

  cov_frame_done: cover property (state_reg == SSTX_DATA ##1 state_reg == SSTX_IDLE);
  cov_delay_path: cover property (state_reg == SSTX_DELAY ##[1:200] state_reg == SSTX_DATA);
  cov_sync_flag: cover property ($rose(tx_sync_reg));
  cov_sync_data: cover property (sync_act_reg && frm_mode_reg.sync_data_enable);
endmodule

/* verification/sstx_codec_model.sv */
// behavioural codec: external clock source and frame word capture
`timescale 1ns/1ps
module sstx_codec_model (
  input  wire logic        sys_clk,
  input  wire logic        ext_run,
  input  wire logic        sample_rise,
  input  wire logic [5:0]  nbits,
  input  wire logic        clk_pin_value,
  input  wire logic        clk_pin_oe,
  input  wire logic        frame_pin_value,
  input  wire logic        frame_pin_oe,
  input  wire logic        data_pin_value,
  output logic             ext_clk,
  output logic [31:0]      word,
  output logic             word_valid
);
  logic [2:0] div = '0;
  logic [2:0] lag = '0;
  logic [5:0] count = '0;
  logic       prev_clk = 1'b0;
  logic       clk_seen;
  logic       hit;
  initial ext_clk = 1'b0;
  initial word = '0;
  initial word_valid = 1'b0;
  assign clk_seen = clk_pin_oe ? clk_pin_value : ext_clk;
  assign hit = (clk_seen != prev_clk) && (clk_seen == sample_rise);
  // clock stands still outside a run, half period of 8 sys cycles
  always_ff @(posedge sys_clk) begin
    div     <= ext_run ? div + 3'h1 : 3'h0;
    ext_clk <= ext_run ? ext_clk ^ (div == 3'h7) : 1'b0;
  end
  // external clock: wait out the device's input synchronizer before sampling
  always_ff @(posedge sys_clk) begin
    prev_clk   <= clk_seen;
    word_valid <= 1'b0;
    lag        <= (hit && !clk_pin_oe) ? 3'h4 : ((lag != 3'h0) ? lag - 3'h1 : 3'h0);
    if (((hit && clk_pin_oe) || lag == 3'h1) && nbits != 6'h0 &&
        (count != 6'h0 || (frame_pin_oe && frame_pin_value))) begin
      word       <= (count == 6'h0) ? {31'h0, data_pin_value} : {word[30:0], data_pin_value};
      count      <= (count + 6'h1 == nbits) ? 6'h0 : count + 6'h1;
      word_valid <= (count + 6'h1 == nbits);
    end
  end
endmodule

/* verification/sstx_core_tb.sv */
// self-checking bench for the serial transmit clock and frame block
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module sstx_core_tb;
  import sstx_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] bus_addr = '0;
  logic [31:0] bus_wdata = '0;
  logic        bus_write = 1'b0;
  logic        bus_read = 1'b0;
  logic [31:0] bus_rdata;
  logic        ck_val;
  logic        ck_oe;
  logic        fr_val;
  logic        fr_oe;
  logic        sd_val;
  logic        sd_oe;
  logic        ext_clk;
  logic        ext_run = 1'b0;
  logic        sample_rise = 1'b1;
  logic [5:0]  nbits = '0;
  logic        rx_start = 1'b0;
  logic        cmp0 = 1'b0;
  logic [31:0] rx_word = '0;
  logic        rx_valid = 1'b0;
  logic [31:0] cap_word;
  logic        cap_valid;
  logic        rd_pend = 1'b0;
  logic [31:0] exp_rd[$];
  logic [31:0] exp_word[$];
  int          bad_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  time         t0;

  always #12.5 sys_clk = ~sys_clk;

  sstx_core u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .tx_clock_pin_level(ck_oe ? ck_val : ext_clk), .tx_clock_pin_value(ck_val),
    .tx_clock_pin_oe(ck_oe), .rx_clock_pin_level(ext_clk),
    // frame line pulled low while nobody drives it
    .tx_frame_pin_level(fr_oe & fr_val), .tx_frame_pin_value(fr_val), .tx_frame_pin_oe(fr_oe),
    .serial_out_pin_value(sd_val), .serial_out_pin_oe(sd_oe), .rx_start(rx_start),
    .compare0_event(cmp0), .received_word(rx_word), .received_word_valid(rx_valid));

  sstx_codec_model u_codec (.sys_clk(sys_clk), .ext_run(ext_run), .sample_rise(sample_rise),
    .nbits(nbits), .clk_pin_value(ck_val), .clk_pin_oe(ck_oe), .frame_pin_value(fr_val),
    .frame_pin_oe(fr_oe), .data_pin_value(sd_val), .ext_clk(ext_clk), .word(cap_word),
    .word_valid(cap_valid));

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge sys_clk);
    bus_write <= 1'b0;
    // one idle edge so a following strobe is never assigned in the same step
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge sys_clk);
    bus_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic frame(input logic [1:0] src, input logic inv, input logic [4:0] len,
                       input logic msb, input logic [3:0] trig);
    logic [31:0] d;
    logic [31:0] e;
    logic        idle;
    d    = $urandom();
    idle = 1'($urandom());
    e    = '0;
    for (int i = 0; i <= len; i++) e[msb ? i : len - i] = d[i];
    sample_rise <= ~inv;
    nbits       <= 6'(len) + 6'h1;
    ext_run     <= (src != 2'h0);
    wr(SSTX_ADDR_CLK_MODE, {16'h0, 4'h0, trig, 2'h0, inv, (src == 2'h0) ? 3'h1 : 3'h0, src});
    // zero delay and no sync data, so no sync bits get cut short
    // positive frame pulse of one clock marks the first bit for the codec
    wr(SSTX_ADDR_FRM_MODE, {8'h00, 8'h20, 8'h00, msb, 1'b0, idle, len});
    wr(SSTX_ADDR_CTRL, 32'h1);
    if (trig == 4'h0) exp_word.push_back(e);
    wr(SSTX_ADDR_TX_HOLD, d);
    if (trig != 4'h0) begin
      repeat (60) @(posedge sys_clk);
      exp_word.push_back(e);
      rx_start <= (trig == 4'h1);
      cmp0     <= (trig == 4'h8);
      @(posedge sys_clk);
      rx_start <= 1'b0;
      cmp0     <= 1'b0;
    end
    for (int n = 0; n < 3000 && exp_word.size() != 0; n++) @(posedge sys_clk);
    `CHK(exp_word.size(), 0)
    repeat (80) @(posedge sys_clk);
    `CHK(sd_val, idle)
    wr(SSTX_ADDR_CTRL, 32'h3);
    repeat (2) @(posedge sys_clk);
    `CHK(sd_oe, idle)
    ext_run <= 1'b0;
    $display("frame test done src=%0d len=%0d trig=%0d", src, len, trig);
  endtask

  always @(posedge sys_clk) begin
    logic [31:0] want;
    rd_pend <= bus_read;
    if (rd_pend) begin
      want = exp_rd.pop_front();
      `CHK(bus_rdata, want)
    end
    if (cap_valid) begin
      want = (exp_word.size() != 0) ? exp_word.pop_front() : ~cap_word;
      `CHK(cap_word, want)
    end
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    logic [31:0] f;
    void'($urandom(32'h532D6037));
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(SSTX_ADDR_CLK_MODE, SSTX_RESET_WORD);
    rd(SSTX_ADDR_FRM_MODE, SSTX_RESET_WORD);
    f = $urandom() & 32'hFFFF0FFF;
    wr(SSTX_ADDR_CLK_MODE, f);
    rd(SSTX_ADDR_CLK_MODE, f);
    f = $urandom() & 32'hF1FF0FBF;
    wr(SSTX_ADDR_FRM_MODE, f);
    wr(SSTX_ADDR_WPROT, 32'h1);
    wr(SSTX_ADDR_FRM_MODE, ~f & 32'hF1FF0FBF);
    rd(SSTX_ADDR_FRM_MODE, f);
    wr(SSTX_ADDR_WPROT, 32'h0);
    rd(32'hF0010004, 32'h0);
    rx_word  <= $urandom();
    rx_valid <= 1'b1;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rd(SSTX_ADDR_RX_HOLD, rx_word);
    for (int k = 0; k < 3; k++) begin
      wr(SSTX_ADDR_CLK_MODE, 32'(k) << 2);
      repeat (2) @(posedge sys_clk);
      `CHK(ck_oe, k == 1)
    end
    for (int k = 0; k < 6; k++) begin
      wr(SSTX_ADDR_FRM_MODE, 32'(k) << 20);
      repeat (3) @(posedge sys_clk);
      `CHK(fr_oe, k != 0)
    end
    $display("register test done");
    frame(2'h0, 1'b0, 5'd7, 1'b1, 4'h0);
    rd(SSTX_ADDR_STATUS, 32'h00010400);
    rd(SSTX_ADDR_STATUS, 32'h00010000);
    frame(2'h0, 1'b1, 5'd15, 1'b0, 4'h0);
    frame(2'h0, 1'b0, 5'd31, 1'b1, 4'h0);
    frame(2'h1, 1'b0, 5'd7, 1'b0, 4'h0);
    frame(2'h2, 1'b1, 5'd9, 1'b1, 4'h0);
    frame(2'h0, 1'b0, 5'd7, 1'b1, 4'h1);
    frame(2'h0, 1'b1, 5'd11, 1'b0, 4'h8);
    nbits <= 6'h0;
    wr(SSTX_ADDR_CLK_MODE, 32'h03000004);
    @(posedge fr_val);
    t0 = $time;
    @(posedge fr_val);
    `CHK(($time - t0) / 25, 2 * 4 * 2 * SSTX_MCK_HALF_CYCLES)
    $display("period test done");
    finish_test();
  end
endmodule
